// *** bsda_top.sv ***
// Bus strobe generator and DMA arbiter with APB control
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
// Operation
// - Float bus when DMA request seen
// - Request release returns bus to processor
// - Grant asserted after bus floated
// - Early protocol: drop grant, await request release
// - Control selects condition input or strobe
// - Pin three drives coprocessor flag three
// - Pin two drives coprocessor flag two
// - Condition inputs pass two-flop synchronisers
// - Strobes enabled for reads, writes, both
// - Peripheral strobe in second transfer cycle
// - Data enable held past strobe end
// - Memory pulse low once per datum
// - Lane selects meaningful for halfword ports only
// - Lane one marks most significant byte
// - Lane zero marks least significant byte
// - Read masking keeps lane selects inactive
// - Lane pins sampled as straps in reset
// - Last flag after next-to-last datum
module bsda_top (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire bsda_pkg::bsda_apb_t         apb_in,
  output logic [31:0]                      prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  input  wire bsda_pkg::bsda_xfer_t        xfer_in,
  input  wire logic                        reclaim_in,
  input  wire logic                        dma_request_n_in,
  output logic                             dma_grant_n_out,
  output logic                             bus_float_out,
  input  wire logic                        ack_n_in,
  input  wire logic                        read_buffer_load_enable_n_in,
  input  wire logic                        sync_branch_input_3_in,
  output logic                             sync_branch_input_3_out,
  output logic                             sync_branch_input_3_oe_out,
  input  wire logic                        sync_branch_input_2_in,
  output logic                             sync_branch_input_2_out,
  output logic                             sync_branch_input_2_oe_out,
  output logic                             coprocessor_flag_3_out,
  output logic                             coprocessor_flag_2_out,
  output logic                             memory_pulse_n_out,
  input  wire logic [1:0]                  halfword_lane_select_n_in,
  output logic [1:0]                       halfword_lane_select_n_out,
  output logic                             halfword_lane_select_oe_out,
  output logic                             last_datum_n_out,
  output logic [1:0]                       strap_out
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [6:0]          sync1;
    logic [6:0]          sync2;
    logic [6:0]          sync3;
    logic [1:0]          strap;
    logic [9:0]          ctrl;
    bsda_pkg::bsda_dma_t dma;
    logic                grant;
    logic                float_bus;
    logic                act_d;
    logic [1:0]          left;
    logic                pstb_n;
    logic                ext_n;
    logic                ext_hold;
    logic                mem_n;
    logic [1:0]          lane_n;
    logic                lane_oe;
    logic                last_n;
    logic                oe3;
    logic                oe2;
    logic                flag3;
    logic                flag2;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } bsda_st_t;

  bsda_st_t s_reg;
  bsda_st_t s_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic rw_en(input logic rd, input logic en_rd, input logic en_wr);
    rw_en = rd ? en_rd : en_wr;
  endfunction

  logic       req;
  logic       act;
  logic       start;
  logic       done;
  logic       setup;
  logic       mapped;
  logic       en_ps;
  logic       en_sd;
  logic       en_mp;
  logic [6:0] raw;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    raw    = {~dma_request_n_in, sync_branch_input_3_in, sync_branch_input_2_in,
              ack_n_in, read_buffer_load_enable_n_in, halfword_lane_select_n_in};
    s_next.sync1 = raw;
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    req   = s_reg.sync2[bsda_pkg::BSDA_SY_REQ];
    act   = xfer_in.active & ~s_reg.float_bus;
    start = act & ~s_reg.act_d;
    done  = act & (xfer_in.is_read ?
            (s_reg.sync3[bsda_pkg::BSDA_SY_RDC] & ~s_reg.sync2[bsda_pkg::BSDA_SY_RDC]) :
            (s_reg.sync3[bsda_pkg::BSDA_SY_ACK] & ~s_reg.sync2[bsda_pkg::BSDA_SY_ACK]));
    en_ps = rw_en(xfer_in.is_read, s_reg.ctrl[bsda_pkg::BSDA_C_PS_RD],
                  s_reg.ctrl[bsda_pkg::BSDA_C_PS_WR]);
    en_sd = rw_en(xfer_in.is_read, s_reg.ctrl[bsda_pkg::BSDA_C_SD_RD],
                  s_reg.ctrl[bsda_pkg::BSDA_C_SD_WR]);
    en_mp = rw_en(xfer_in.is_read, s_reg.ctrl[bsda_pkg::BSDA_C_MP_RD],
                  s_reg.ctrl[bsda_pkg::BSDA_C_MP_WR]);

    // DMA arbitration
    case (s_reg.dma)
      bsda_pkg::BSDA_OWN: begin
        if (req && !act) begin
          s_next.dma       = bsda_pkg::BSDA_FLOAT;
          s_next.float_bus = 1'b1;
        end
      end
      bsda_pkg::BSDA_FLOAT: begin
        s_next.dma   = bsda_pkg::BSDA_GRANT;
        s_next.grant = 1'b1;
      end
      bsda_pkg::BSDA_GRANT: begin
        if (!req) begin
          s_next.dma       = bsda_pkg::BSDA_OWN;
          s_next.grant     = 1'b0;
          s_next.float_bus = 1'b0;
        end else if (s_reg.ctrl[bsda_pkg::BSDA_C_EARLY] && reclaim_in) begin
          s_next.dma   = bsda_pkg::BSDA_RECLAIM;
          s_next.grant = 1'b0;
        end
      end
      bsda_pkg::BSDA_RECLAIM: begin
        if (!req) begin
          s_next.dma       = bsda_pkg::BSDA_OWN;
          s_next.float_bus = 1'b0;
        end
      end
      default: begin
        s_next.dma       = bsda_pkg::BSDA_OWN;
        s_next.grant     = 1'b0;
        s_next.float_bus = 1'b0;
      end
    endcase

    // Transfer strobes
    s_next.act_d  = act;
    s_next.left   = start ? xfer_in.datums :
                    ((done && s_reg.left != 2'h0) ? s_reg.left - 2'h1 : s_reg.left);
    s_next.pstb_n = ~(start & en_ps);
    s_next.ext_hold = act & en_sd;
    s_next.ext_n  = ~((act & en_sd) | s_reg.ext_hold);
    s_next.mem_n  = ~(en_mp & (start | (done & s_reg.left != 2'h0)));
    s_next.last_n = ~(act & (start ? (xfer_in.datums == 2'h0) :
                    (s_reg.left == 2'h0 || (done && s_reg.left == 2'h1))));
    if (act && xfer_in.port16 &&
        !(xfer_in.is_read && s_reg.ctrl[bsda_pkg::BSDA_C_RMASK])) begin
      s_next.lane_n = ~xfer_in.lanes;
    end else begin
      s_next.lane_n = 2'h3;
    end
    s_next.lane_oe = ~s_next.float_bus;

    // Shared pins
    s_next.oe3   = ~s_reg.ctrl[bsda_pkg::BSDA_C_BR3] & ~s_next.float_bus;
    s_next.oe2   = ~s_reg.ctrl[bsda_pkg::BSDA_C_BR2] & ~s_next.float_bus;
    s_next.flag3 = s_reg.ctrl[bsda_pkg::BSDA_C_BR3] &
                   s_reg.sync2[bsda_pkg::BSDA_SY_B3];
    s_next.flag2 = s_reg.ctrl[bsda_pkg::BSDA_C_BR2] &
                   s_reg.sync2[bsda_pkg::BSDA_SY_B2];

    // APB slave
    setup  = apb_in.psel & ~apb_in.penable;
    mapped = hit(apb_in.paddr, bsda_pkg::BSDA_CTRL_OFS) |
             hit(apb_in.paddr, bsda_pkg::BSDA_STAT_OFS);
    s_next.pready  = setup;
    s_next.pslverr = setup & ~mapped;
    s_next.prdata  = 32'h0;
    if (setup && !apb_in.pwrite && hit(apb_in.paddr, bsda_pkg::BSDA_CTRL_OFS)) begin
      s_next.prdata = {22'h0, s_reg.ctrl};
    end else if (setup && !apb_in.pwrite && hit(apb_in.paddr, bsda_pkg::BSDA_STAT_OFS)) begin
      s_next.prdata = {25'h0, act, s_reg.strap, s_reg.flag2, s_reg.flag3,
                       s_reg.float_bus, s_reg.grant};
    end
    if (apb_in.psel && apb_in.penable && s_reg.pready && apb_in.pwrite &&
        hit(apb_in.paddr, bsda_pkg::BSDA_CTRL_OFS)) begin
      s_next.ctrl = apb_in.pwdata[9:0];
    end

    // Reset, straps sampled while held
    if (rst_in) begin
      s_next          = '0;
      s_next.sync1    = raw;
      s_next.sync2    = s_reg.sync1;
      s_next.sync3    = s_reg.sync2;
      s_next.strap    = s_reg.sync2[1:0];
      s_next.ctrl     = bsda_pkg::BSDA_CTRL_RST;
      s_next.dma      = bsda_pkg::BSDA_OWN;
      s_next.pstb_n   = 1'b1;
      s_next.ext_n    = 1'b1;
      s_next.mem_n    = 1'b1;
      s_next.lane_n   = 2'h3;
      s_next.last_n   = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    s_reg <= s_next;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata_out                  = s_reg.prdata;
  assign pready_out                  = s_reg.pready;
  assign pslverr_out                 = s_reg.pslverr;
  assign dma_grant_n_out             = ~s_reg.grant;
  assign bus_float_out               = s_reg.float_bus;
  assign sync_branch_input_3_out     = s_reg.pstb_n;
  assign sync_branch_input_3_oe_out  = s_reg.oe3;
  assign sync_branch_input_2_out     = s_reg.ext_n;
  assign sync_branch_input_2_oe_out  = s_reg.oe2;
  assign coprocessor_flag_3_out      = s_reg.flag3;
  assign coprocessor_flag_2_out      = s_reg.flag2;
  assign memory_pulse_n_out          = s_reg.mem_n;
  assign halfword_lane_select_n_out  = s_reg.lane_n;
  assign halfword_lane_select_oe_out = s_reg.lane_oe;
  assign last_datum_n_out            = s_reg.last_n;
  assign strap_out                   = s_reg.strap;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  chk_float_on_req: assert property (
    s_reg.dma == bsda_pkg::BSDA_OWN && req && !act |=> s_reg.float_bus ##1 s_reg.grant)
    else $error("bus not floated on request");

  chk_resume_bus: assert property (
    s_reg.dma == bsda_pkg::BSDA_GRANT && !req |=> !s_reg.float_bus && !s_reg.grant)
    else $error("bus not resumed after release");

  chk_grant_float: assert property (
    $rose(s_reg.grant) |-> s_reg.float_bus && $past(s_reg.float_bus))
    else $error("grant before bus floated");

  chk_reclaim_wait: assert property (
    s_reg.dma == bsda_pkg::BSDA_RECLAIM && req |=> s_reg.float_bus && !s_reg.grant)
    else $error("bus retaken before request release");

  chk_grant_hold: assert property (
    s_reg.grant && req && !s_reg.ctrl[bsda_pkg::BSDA_C_EARLY] |=> s_reg.grant)
    else $error("grant dropped while requested");

  chk_flag3_path: assert property (
    s_reg.ctrl[bsda_pkg::BSDA_C_BR3] && $past(s_reg.ctrl[bsda_pkg::BSDA_C_BR3], 3)
    |-> s_reg.flag3 == $past(sync_branch_input_3_in, 3))
    else $error("flag three not synchronised input");

  chk_flag2_path: assert property (
    s_reg.ctrl[bsda_pkg::BSDA_C_BR2] && $past(s_reg.ctrl[bsda_pkg::BSDA_C_BR2], 3)
    |-> s_reg.flag2 == $past(sync_branch_input_2_in, 3))
    else $error("flag two not synchronised input");

  chk_pstrobe_second: assert property (
    start && en_ps |=> !s_reg.pstb_n ##1 s_reg.pstb_n)
    else $error("peripheral strobe not in second cycle");

  chk_stretch_hold: assert property (
    act && en_sd ##1 !act |=> !s_reg.ext_n ##1 s_reg.ext_n)
    else $error("data enable not stretched one cycle");

  chk_mem_single: assert property (
    !s_reg.mem_n |=> s_reg.mem_n)
    else $error("memory pulse longer than one cycle");

  chk_lane_mask: assert property (
    act && xfer_in.is_read && s_reg.ctrl[bsda_pkg::BSDA_C_RMASK] |=> s_reg.lane_n == 2'h3)
    else $error("lane select active on masked read");

  chk_last_clear: assert property (
    !act |=> s_reg.last_n)
    else $error("last flag held after strobe end");

  chk_pin3_mode: assert property (
    $past(s_reg.ctrl[bsda_pkg::BSDA_C_BR3]) |-> !s_reg.oe3)
    else $error("pin three driven in branch mode");

  chk_pin2_mode: assert property (
    $past(s_reg.ctrl[bsda_pkg::BSDA_C_BR2]) |-> !s_reg.oe2)
    else $error("pin two driven in branch mode");

  chk_float_pins: assert property (
    s_reg.float_bus |-> !s_reg.oe3 && !s_reg.oe2 && !s_reg.lane_oe)
    else $error("pins driven while bus floated");

  chk_mem_start: assert property (
    start && en_mp |=> !s_reg.mem_n)
    else $error("memory pulse missing at transfer start");

  chk_stretch_on: assert property (
    act && en_sd |=> !s_reg.ext_n)
    else $error("data enable missing during transfer");

  chk_lane_value: assert property (
    act && xfer_in.port16 && !xfer_in.is_read |=> s_reg.lane_n == ~$past(xfer_in.lanes))
    else $error("lane selects do not match used bytes");

  chk_last_start: assert property (
    start && xfer_in.datums != 2'h0 |=> s_reg.last_n)
    else $error("last flag early on multi-datum transfer");

  chk_grant_drop: assert property (
    s_reg.grant && !req |=> !s_reg.grant)
    else $error("grant held after request release");

  cov_dma_grant: cover property (s_reg.dma == bsda_pkg::BSDA_FLOAT ##1 s_reg.grant);
  cov_reclaim: cover property (s_reg.dma == bsda_pkg::BSDA_RECLAIM ##[1:20] !s_reg.float_bus);
  cov_burst_last: cover property (start && xfer_in.datums == 2'h3 ##[1:60] !s_reg.last_n);
  cov_masked_read: cover property (start && xfer_in.is_read &&
                                   s_reg.ctrl[bsda_pkg::BSDA_C_RMASK]);
  cov_flag3_rise: cover property ($rose(s_reg.flag3));

endmodule

// *** bsda_pkg.sv ***
// Package: bus strobe and DMA arbiter constants and types
package bsda_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int             BSDA_AW       = 8;
  localparam logic [7:0]     BSDA_CTRL_OFS = 8'h00;
  localparam logic [7:0]     BSDA_STAT_OFS = 8'h04;
  localparam logic [9:0]     BSDA_CTRL_RST = 10'h003;

  // ------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------
  localparam int BSDA_C_BR3   = 0;
  localparam int BSDA_C_BR2   = 1;
  localparam int BSDA_C_PS_RD = 2;
  localparam int BSDA_C_PS_WR = 3;
  localparam int BSDA_C_SD_RD = 4;
  localparam int BSDA_C_SD_WR = 5;
  localparam int BSDA_C_MP_RD = 6;
  localparam int BSDA_C_MP_WR = 7;
  localparam int BSDA_C_RMASK = 8;
  localparam int BSDA_C_EARLY = 9;

  // ------------------------------------------------------------
  // Synchroniser bit positions
  // ------------------------------------------------------------
  localparam int BSDA_SY_REQ  = 6;
  localparam int BSDA_SY_B3   = 5;
  localparam int BSDA_SY_B2   = 4;
  localparam int BSDA_SY_ACK  = 3;
  localparam int BSDA_SY_RDC  = 2;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    BSDA_OWN     = 4'b0001,
    BSDA_FLOAT   = 4'b0010,
    BSDA_GRANT   = 4'b0100,
    BSDA_RECLAIM = 4'b1000
  } bsda_dma_t;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [BSDA_AW-1:0]  paddr;
    logic [31:0]         pwdata;
  } bsda_apb_t;

  typedef struct packed {
    logic       active;
    logic       is_read;
    logic       port16;
    logic [1:0] lanes;
    logic [1:0] datums;
  } bsda_xfer_t;

endpackage

// *** bsda_partner.sv ***
// Model of the DMA master and the memory system
`timescale 1ns/1ps
module bsda_partner (
  input  wire logic                 clk_in,
  input  wire bsda_pkg::bsda_xfer_t xfer_in,
  input  wire logic                 slow_in,
  input  wire logic                 want_dma_in,
  input  wire logic                 dma_grant_n_in,
  output logic                      dma_request_n_out,
  output logic                      ack_n_out,
  output logic                      load_n_out
);
  int   cnt;
  int   sent;
  logic granted;
  initial begin
    dma_request_n_out = 1'b1;
    ack_n_out = 1'b1;
    load_n_out = 1'b1;
    granted = 1'b0;
    cnt = 0;
    sent = 0;
  end
  // ----------------------------------------
  // Bus request
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!want_dma_in) begin
      dma_request_n_out <= 1'b1;
      granted <= 1'b0;
    end else if (!granted) begin
      dma_request_n_out <= 1'b0;
      if (dma_grant_n_in == 1'b0) granted <= 1'b1;
    end else if (dma_grant_n_in) begin
      dma_request_n_out <= 1'b1;
    end
  end
  // ----------------------------------------
  // Datum answers, one fall per datum
  // ----------------------------------------
  always @(posedge clk_in) begin
    ack_n_out <= 1'b1;
    load_n_out <= 1'b1;
    if (!xfer_in.active) begin
      cnt <= 0;
      sent <= 0;
    end else if (sent <= xfer_in.datums) begin
      cnt <= cnt + 1;
      if (cnt == (slow_in ? 6 : 3)) begin
        cnt <= 0;
        sent <= sent + 1;
        if (xfer_in.is_read) load_n_out <= 1'b0;
        else ack_n_out <= 1'b0;
      end
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the strobe generator and DMA arbiter
`timescale 1ns/1ps
module testbench;
  logic clk_in, rst_in, reclaim, slow, want, br3, br2, req_n, ack_n, load_n;
  bsda_pkg::bsda_apb_t  apb_drv;
  bsda_pkg::bsda_xfer_t xfer_drv;
  logic [31:0] prdata;
  logic        pready, pslverr, grant_n, flt, s3, s3_oe, s2, s2_oe, f3, f2, mem_n, last_n;
  logic [1:0]  lane_n, lane_w, strap;
  logic        lane_oe;
  wire         s3_w = s3_oe ? s3 : br3;
  wire         s2_w = s2_oe ? s2 : br2;
  int          err_total, comparisons, cycles, mem_cnt, pstb_cnt;
  assign lane_w = lane_oe ? lane_n : 2'b11;
  bsda_top u_bsda_top (.clk_in(clk_in), .rst_in(rst_in), .apb_in(apb_drv),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .xfer_in(xfer_drv),
    .reclaim_in(reclaim), .dma_request_n_in(req_n), .dma_grant_n_out(grant_n),
    .bus_float_out(flt), .ack_n_in(ack_n), .read_buffer_load_enable_n_in(load_n),
    .sync_branch_input_3_in(s3_w), .sync_branch_input_3_out(s3),
    .sync_branch_input_3_oe_out(s3_oe), .sync_branch_input_2_in(s2_w),
    .sync_branch_input_2_out(s2), .sync_branch_input_2_oe_out(s2_oe),
    .coprocessor_flag_3_out(f3), .coprocessor_flag_2_out(f2), .memory_pulse_n_out(mem_n),
    .halfword_lane_select_n_in(lane_w), .halfword_lane_select_n_out(lane_n),
    .halfword_lane_select_oe_out(lane_oe), .last_datum_n_out(last_n), .strap_out(strap));
  bsda_partner u_bsda_partner (.clk_in(clk_in), .xfer_in(xfer_drv), .slow_in(slow),
    .want_dma_in(want), .dma_grant_n_in(grant_n), .dma_request_n_out(req_n),
    .ack_n_out(ack_n), .load_n_out(load_n));
  // ----------------------------------------
  // Clock, timeout, monitors
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (mem_n === 1'b0) mem_cnt++;
    if (s3 === 1'b0 && s3_oe === 1'b1) pstb_cnt++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_in);
    apb_drv <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    apb_drv.penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    apb_drv <= '0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    chk(strap === 2'b11, "strap value");
    chk(s3_oe === 1'b0 && grant_n === 1'b1, "pin idle");
    apb(1'b0, bsda_pkg::BSDA_CTRL_OFS, 32'h0, r, e);
    chk(r === 32'h0000_0003 && e === 1'b0, "control reset");
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk(r === 32'h0 && e === 1'b1, "unmapped read");
    $display("reset test done");
  endtask
  task automatic t_branch();
    br3 <= 1'b1;
    tick();
    chk(f3 === 1'b0, "flag too early");
    repeat (4) tick();
    chk(f3 === 1'b1 && f2 === 1'b0, "flags 1 0");
    @(posedge clk_in);
    br3 <= 1'b0;
    br2 <= 1'b1;
    repeat (5) tick();
    chk(f3 === 1'b0 && f2 === 1'b1, "flags 0 1");
    $display("branch test done");
  endtask
  task automatic t_xfer(input logic [9:0] c, input logic rd, input logic [1:0] ln,
                        input logic [1:0] dn, input int pn, input logic [1:0] el, input int mn);
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b1, bsda_pkg::BSDA_CTRL_OFS, {22'h0, c}, r, e);
    mem_cnt = 0;
    pstb_cnt = 0;
    @(posedge clk_in);
    xfer_drv <= '{1'b1, rd, 1'b1, ln, dn};
    slow <= ~rd;
    tick();
    chk(s3 === (pn == 0) && s3_oe === 1'b1 && s2_oe === 1'b1, "strobe at start");
    chk(s2 === 1'b0, "data enable on");
    chk(lane_n === el, "lane selects");
    chk(last_n === (dn != 0), "last at start");
    tick();
    chk(s3 === 1'b1, "strobe one cycle");
    n = 0;
    while (last_n !== 1'b0 && n < 60) begin
      tick();
      n++;
    end
    chk(last_n === 1'b0, "last asserted");
    repeat (40) tick();
    chk(mem_cnt == mn, "memory pulse count");
    chk(pstb_cnt == pn, "strobe count");
    @(posedge clk_in);
    xfer_drv.active <= 1'b0;
    tick();
    chk(s2 === 1'b0 && last_n === 1'b1, "stretch and last end");
    tick();
    chk(s2 === 1'b1, "stretch over");
    $display("transfer test done");
  endtask
  task automatic t_dma(input logic early);
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b1, bsda_pkg::BSDA_CTRL_OFS, {22'h0, early, 9'h003}, r, e);
    want <= 1'b1;
    n = 0;
    while (grant_n !== 1'b0 && n < 20) begin
      tick();
      n++;
    end
    chk(grant_n === 1'b0 && flt === 1'b1 && lane_oe === 1'b0, "granted");
    apb(1'b0, bsda_pkg::BSDA_STAT_OFS, 32'h0, r, e);
    chk(r === 32'h0000_003b && e === 1'b0, "status while granted");
    if (early) begin
      @(posedge clk_in);
      reclaim <= 1'b1;
      n = 0;
      while (grant_n !== 1'b1 && n < 20) begin
        tick();
        n++;
      end
      chk(grant_n === 1'b1 && flt === 1'b1, "early withdraw");
    end else begin
      repeat (10) tick();
      chk(grant_n === 1'b0, "grant held");
      @(posedge clk_in);
      want <= 1'b0;
    end
    n = 0;
    while (flt !== 1'b0 && n < 20) begin
      tick();
      n++;
    end
    chk(flt === 1'b0 && grant_n === 1'b1, "bus back");
    @(posedge clk_in);
    want <= 1'b0;
    reclaim <= 1'b0;
    $display("dma test done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_in = 1'b1;
    apb_drv = '0;
    xfer_drv = '0;
    reclaim = 1'b0;
    slow = 1'b0;
    want = 1'b0;
    br3 = 1'b0;
    br2 = 1'b0;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    tick();
    t_reset();
    t_branch();
    t_xfer(10'h0fc, 1'b1, 2'b11, 2'd1, 1, 2'b00, 2);
    t_xfer(10'h1b4, 1'b1, 2'b11, 2'd0, 1, 2'b11, 0);
    t_xfer(10'h1b4, 1'b0, 2'b10, 2'd3, 0, 2'b01, 4);
    t_dma(1'b0);
    t_dma(1'b1);
    stop_test();
  end
endmodule
